// ==== pkg/smw_pkg.sv ====
// Constants, field layouts and helper functions of the sleep entry and wake controller.
// How it works
// (R01) A sleep command while the idle select bit is clear takes the controller into full sleep.
// (R02) Every device reset returns the idle select bit to zero, so sleep is the default.
// (R03) Entering sleep turns off the oscillator that currently clocks the core.
// (R04) Entering sleep clears all clock source status flags.
// (R05) Sleep is entered at once even while a clock switch is still pending.
// (R06) With the watchdog enabled the internal RC oscillator keeps running during sleep.
// (R07) With the secondary timer oscillator enabled it keeps running during sleep.
// (R08) An interrupt, a device reset or a watchdog time-out ends sleep.
// (R09) After a wake the core stays unclocked until the selected source reports ready.
// (R10) With two-speed start-up or the fail-safe monitor on, the core runs from the internal oscillator while it waits.
// (R11) The primary clock running flag is set once the primary clock drives the core.
// (R12) An interrupt or watchdog wake leaves the idle select bit and the system clock select field untouched.
// (R13) An interrupt wake with a global enable set pushes the program counter and bumps the stack pointer.
// (R14) That same wake loads the program counter with the high or low priority vector.
package smw_pkg;
  localparam int          NSRC      = 3;
  localparam logic [1:0]  SRC_PRI   = 2'h0;
  localparam logic [1:0]  SRC_SEC   = 2'h1;
  localparam logic [1:0]  SRC_INT   = 2'h2;
  localparam logic [1:0]  SEL_INT   = 2'h2;
  localparam int          PC_W      = 21;
  localparam int          SP_W      = 5;
  localparam int          STK_DEPTH = 31;
  localparam logic [20:0] VEC_HIGH  = 21'h000008;
  localparam logic [20:0] VEC_LOW   = 21'h000018;
  localparam logic [4:0]  OFF_CTRL  = 5'h00;
  localparam logic [4:0]  OFF_STAT  = 5'h04;
  localparam logic [4:0]  OFF_CMD   = 5'h08;
  localparam logic [4:0]  OFF_PC    = 5'h0C;
  localparam logic [4:0]  OFF_SP    = 5'h10;
  localparam logic [4:0]  OFF_TOS   = 5'h14;
  localparam int          B_IDLE    = 0;
  localparam int          B_SCS_LO  = 1;
  localparam int          B_SCS_HI  = 2;
  localparam int          B_TWOSPD  = 3;
  localparam int          B_FAILSAFE = 4;
  localparam int          B_WDOG     = 5;
  localparam int          B_SECOSC  = 6;
  localparam int          B_IRQ_HI   = 7;
  localparam int          B_IRQ_LO   = 8;
  localparam int          B_CMD_SLP = 0;
  localparam int          B_ST_SLP  = 3;
  localparam int          B_ST_IDL  = 4;
  localparam int          B_ST_WT   = 5;
  localparam logic [31:0] CTRL_RST  = 32'h00000000;
  localparam logic [31:0] CTRL_MASK = 32'h000001FF;

  typedef enum logic [2:0] {SMW_RUN, SMW_IDLE, SMW_SLEEP, SMW_WAIT, SMW_TWOSPD} smw_state_t;

  // Maps a system clock select code onto an oscillator index.
  function automatic logic [1:0] src_of(input logic [1:0] sel);
    src_of = sel[1] ? SRC_INT : {1'b0, sel[0]};
  endfunction : src_of

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      old_v[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
    be_merge = old_v;
  endfunction : be_merge
endpackage : smw_pkg

// ==== pkg/smw_if.sv ====
// Internal carrier between the controller and its oscillator and vector units.
`timescale 1ns/1ps
interface smw_if;
  logic        asleep;
  logic        fast_start;
  logic        sec_on;
  logic        wdog_on;
  logic [1:0]  act_src;
  logic [1:0]  tgt_src;
  logic [2:0]  osc_en;
  logic        push;
  logic        vec_high;
  logic        pc_wr;
  logic [20:0] pc_wdata;
  logic [20:0] pc;
  logic [20:0] tos;
  logic [4:0]  sp;

  modport top (output asleep, fast_start, sec_on, wdog_on, act_src, tgt_src,
               output push, vec_high, pc_wr, pc_wdata,
               input  osc_en, pc, tos, sp);
  modport clk (input asleep, fast_start, sec_on, wdog_on, act_src, tgt_src,
               output osc_en);
  modport vec (input push, vec_high, pc_wr, pc_wdata,
               output pc, tos, sp);
endinterface : smw_if

// ==== rtl/smw_osc_ctrl.sv ====
// Oscillator enable unit: decides which sources run in each power state.
`timescale 1ns/1ps
module smw_osc_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  smw_if.clk       bus
);
  logic [2:0] osc_en_q;
  logic [2:0] keep;
  logic [2:0] want;

  // Only the watchdog and secondary oscillators may survive sleep.
  assign keep = {bus.wdog_on, bus.sec_on, 1'b0}; // [R06] [R07]
  assign bus.osc_en = osc_en_q;

  for (genvar k = 0; k < smw_pkg::NSRC; k++) begin : g_src
    // The target source stays on outside sleep so that it can become ready.
    assign want[k] = (smw_pkg::src_of(bus.act_src) == 2'(k))
                   | (smw_pkg::src_of(bus.tgt_src) == 2'(k))
                   | ((2'(k) == smw_pkg::SRC_INT) & bus.fast_start);
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        osc_en_q[k] <= 1'b0;
      end else begin
        osc_en_q[k] <= bus.asleep ? keep[k] : (want[k] | keep[k]); // [R03]
      end
    end
  end
endmodule : smw_osc_ctrl

// ==== rtl/smw_vector.sv ====
// Program counter, return stack and interrupt vector load on wake.
`timescale 1ns/1ps
module smw_vector (
  input wire logic ref_clk,
  input wire logic rst_n,
  smw_if.vec       bus
);
  logic [20:0] stack [0:smw_pkg::STK_DEPTH-1];
  logic [20:0] pc_q;
  logic [20:0] tos_q;
  logic [4:0]  sp_q;
  logic        room;

  // A full stack drops the push rather than wrapping over the oldest entry.
  assign room     = sp_q < 5'(smw_pkg::STK_DEPTH);
  assign bus.pc   = pc_q;
  assign bus.tos  = tos_q;
  assign bus.sp   = sp_q;

  always_ff @(posedge ref_clk) begin
    if (bus.push && room) begin
      stack[sp_q] <= pc_q; // [R13]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q  <= 21'h000000;
      tos_q <= 21'h000000;
      sp_q  <= 5'h00;
    end else if (bus.push) begin
      tos_q <= pc_q; // [R13]
      sp_q  <= room ? sp_q + 5'h01 : sp_q; // [R13]
      pc_q  <= bus.vec_high ? smw_pkg::VEC_HIGH : smw_pkg::VEC_LOW; // [R14]
    end else if (bus.pc_wr) begin
      pc_q  <= bus.pc_wdata;
    end
  end
endmodule : smw_vector

// ==== rtl/smw_top.sv ====
// Sleep entry and wake controller with its Avalon-MM register slave.
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module smw_top (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output wire logic [31:0] avs_readdata,
  output wire logic        avs_waitrequest,
  input  wire logic        irq_req,
  input  wire logic        irq_high_pri,
  input  wire logic        wdog_timeout,
  input  wire logic        dev_reset,
  input  wire logic [2:0]  src_ready,
  output wire logic        core_clk_en,
  output wire logic [1:0]  core_clk_src,
  output wire logic        cpu_halted,
  output wire logic [2:0]  osc_en,
  output wire logic [20:0] prog_counter
);
  smw_if bus ();

  smw_pkg::smw_state_t st_q;
  smw_pkg::smw_state_t st_d;

  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic        wait_q;
  logic [1:0]  act_q;
  logic [1:0]  act_d;
  logic [1:0]  core_src_q;
  logic [1:0]  core_src_d;
  logic        core_en_q;
  logic        halt_q;
  logic [2:0]  flags_q;
  logic [2:0]  flags_d;

  // Bus decode.
  logic        req;
  logic        acc;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_cmd;
  logic        hit_pc;
  logic        hit_sp;
  logic        hit_tos;
  logic        wr_ctrl;
  logic        sleep_cmd;
  logic [31:0] status_w;
  logic [31:0] pc_merge;

  // Control fields.
  logic        idle_select_bit;
  logic [1:0]  system_clock_select;
  logic [1:0]  tgt_idx;
  logic        tgt_ready;
  logic        fast_wake;
  logic        gie_any;
  logic        wake_any;
  logic        vec_take;
  logic        switch_ok;
  logic        clocked_d;

  assign req      = avs_read | avs_write;
  assign acc      = req & ~wait_q;
  assign hit_ctrl = avs_address == smw_pkg::OFF_CTRL;
  assign hit_stat = avs_address == smw_pkg::OFF_STAT;
  assign hit_cmd  = avs_address == smw_pkg::OFF_CMD;
  assign hit_pc   = avs_address == smw_pkg::OFF_PC;
  assign hit_sp   = avs_address == smw_pkg::OFF_SP;
  assign hit_tos  = avs_address == smw_pkg::OFF_TOS;
  assign wr_ctrl  = avs_write & acc & hit_ctrl;

  // The core can only issue the sleep instruction while it runs.
  assign sleep_cmd = avs_write & acc & hit_cmd & avs_byteenable[0]
                   & avs_writedata[smw_pkg::B_CMD_SLP] & (st_q == smw_pkg::SMW_RUN);

  assign idle_select_bit     = ctrl_q[smw_pkg::B_IDLE];
  assign system_clock_select = ctrl_q[smw_pkg::B_SCS_HI:smw_pkg::B_SCS_LO];
  assign tgt_idx             = smw_pkg::src_of(system_clock_select);
  assign tgt_ready           = src_ready[tgt_idx];
  assign fast_wake           = ctrl_q[smw_pkg::B_TWOSPD] | ctrl_q[smw_pkg::B_FAILSAFE];
  assign gie_any             = ctrl_q[smw_pkg::B_IRQ_HI] | ctrl_q[smw_pkg::B_IRQ_LO];
  assign wake_any            = irq_req | wdog_timeout | dev_reset; // [R08]

  // A device reset wins over an interrupt, so it never vectors.
  assign vec_take = irq_req & gie_any & ~dev_reset
                  & ((st_q == smw_pkg::SMW_SLEEP) | (st_q == smw_pkg::SMW_IDLE)); // [R13] [R14]

  // A running clock switch completes only when the new source is ready.
  assign switch_ok = (st_q == smw_pkg::SMW_RUN) & ~sleep_cmd & tgt_ready;

  // Status word: clock source flags plus state summary bits.
  assign status_w = {26'h0000000,
                     st_q == smw_pkg::SMW_WAIT || st_q == smw_pkg::SMW_TWOSPD,
                     st_q == smw_pkg::SMW_IDLE,
                     st_q == smw_pkg::SMW_SLEEP,
                     flags_q};

  assign rd_mux = hit_ctrl ? ctrl_q :
                  hit_stat ? status_w :
                  hit_pc   ? {11'h000, bus.pc} :
                  hit_sp   ? {27'h0000000, bus.sp} :
                  hit_tos  ? {11'h000, bus.tos} :
                  32'h00000000;

  // Control register: only software or a device reset may change it, never a wake.
  assign ctrl_d = dev_reset ? smw_pkg::CTRL_RST : // [R02]
                  wr_ctrl   ? smw_pkg::be_merge(ctrl_q, avs_writedata, avs_byteenable)
                              & smw_pkg::CTRL_MASK :
                  ctrl_q; // [R12]

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      smw_pkg::SMW_RUN: begin
        // Sleep does not wait for a pending switch; no clock is needed once asleep.
        if (sleep_cmd) begin
          st_d = idle_select_bit ? smw_pkg::SMW_IDLE : smw_pkg::SMW_SLEEP; // [R01] [R05]
        end
      end
      smw_pkg::SMW_IDLE: begin
        if (wake_any) begin
          st_d = smw_pkg::SMW_RUN;
        end
      end
      smw_pkg::SMW_SLEEP: begin
        if (wake_any) begin
          st_d = fast_wake ? smw_pkg::SMW_TWOSPD : smw_pkg::SMW_WAIT; // [R08] [R10]
        end
      end
      smw_pkg::SMW_WAIT: begin
        if (tgt_ready) begin
          st_d = smw_pkg::SMW_RUN; // [R09]
        end
      end
      smw_pkg::SMW_TWOSPD: begin
        if (tgt_ready) begin
          st_d = smw_pkg::SMW_RUN; // [R10]
        end
      end
    endcase
  end

  assign act_d = (switch_ok || (st_q == smw_pkg::SMW_WAIT && tgt_ready)
                  || (st_q == smw_pkg::SMW_TWOSPD && tgt_ready))
                 ? system_clock_select : act_q;

  assign clocked_d = (st_d == smw_pkg::SMW_RUN) | (st_d == smw_pkg::SMW_IDLE)
                   | (st_d == smw_pkg::SMW_TWOSPD); // [R09]

  // While waiting with fast start the core borrows the internal oscillator.
  assign core_src_d = (st_d == smw_pkg::SMW_TWOSPD) ? smw_pkg::SEL_INT : act_d; // [R10]

  for (genvar k = 0; k < smw_pkg::NSRC; k++) begin : g_flag
    // Sleep and the unclocked wait leave every flag clear.
    assign flags_d[k] = clocked_d & (smw_pkg::src_of(core_src_d) == 2'(k)); // [R04] [R11]
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q  <= ~(req & wait_q);
      rdata_q <= (avs_read & wait_q) ? rd_mux : rdata_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= smw_pkg::CTRL_RST; // [R02]
      st_q   <= smw_pkg::SMW_RUN;
      act_q  <= smw_pkg::SRC_PRI;
    end else begin
      ctrl_q <= ctrl_d;
      st_q   <= st_d;
      act_q  <= act_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_en_q  <= 1'b1;
      core_src_q <= smw_pkg::SRC_PRI;
      halt_q     <= 1'b0;
      flags_q    <= 3'h1;
    end else begin
      core_en_q  <= clocked_d;
      core_src_q <= core_src_d;
      halt_q     <= st_d != smw_pkg::SMW_RUN;
      flags_q    <= flags_d;
    end
  end

  assign bus.asleep     = st_q == smw_pkg::SMW_SLEEP;
  assign bus.fast_start = st_q == smw_pkg::SMW_TWOSPD;
  assign bus.sec_on     = ctrl_q[smw_pkg::B_SECOSC];
  assign bus.wdog_on    = ctrl_q[smw_pkg::B_WDOG];
  assign bus.act_src    = act_q;
  assign bus.tgt_src    = system_clock_select;
  assign bus.push       = vec_take;
  assign bus.vec_high   = irq_high_pri;
  assign bus.pc_wr      = avs_write & acc & hit_pc;
  assign pc_merge       = smw_pkg::be_merge({11'h000, bus.pc}, avs_writedata,
                                            avs_byteenable);
  // Only the low 21 bits form the program counter; the upper lanes are dropped on purpose.
  assign bus.pc_wdata   = pc_merge[20:0];

  smw_osc_ctrl u_osc (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .bus     (bus.clk)
  );

  smw_vector u_vec (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .bus     (bus.vec)
  );

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign core_clk_en     = core_en_q;
  assign core_clk_src    = core_src_q;
  assign cpu_halted      = halt_q;
  assign osc_en          = bus.osc_en;
  assign prog_counter    = bus.pc;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sleep_entry_a: assert property (sleep_cmd && !idle_select_bit |=> // [R01]
    st_q == smw_pkg::SMW_SLEEP && halt_q && !core_en_q)
    else $error("sleep command did not enter sleep");

  idle_reset_a: assert property (dev_reset |=> !idle_select_bit // [R02]
    && system_clock_select == 2'h0)
    else $error("device reset left idle select set");

  osc_stop_a: assert property (st_q == smw_pkg::SMW_SLEEP // [R03]
    && $past(st_q == smw_pkg::SMW_SLEEP) && act_q == smw_pkg::SRC_PRI
    |-> !osc_en[smw_pkg::SRC_PRI])
    else $error("primary oscillator runs in sleep");

  flags_clear_a: assert property ($rose(st_q == smw_pkg::SMW_SLEEP) // [R04]
    |-> flags_q == 3'h0 ##1 flags_q == 3'h0)
    else $error("clock status flags not cleared in sleep");

  no_switch_a: assert property (sleep_cmd && !idle_select_bit && !tgt_ready // [R05]
    |=> st_q == smw_pkg::SMW_SLEEP && act_q == $past(act_q))
    else $error("sleep entry waited on clock switch");

  rc_keep_a: assert property (st_q == smw_pkg::SMW_SLEEP // [R06]
    && $past(st_q == smw_pkg::SMW_SLEEP) && $past(bus.wdog_on)
    |-> osc_en[smw_pkg::SRC_INT])
    else $error("internal oscillator stopped with watchdog on");

  secosc_keep_a: assert property (st_q == smw_pkg::SMW_SLEEP // [R07]
    && $past(st_q == smw_pkg::SMW_SLEEP) && $past(bus.sec_on)
    |-> osc_en[smw_pkg::SRC_SEC])
    else $error("secondary oscillator stopped in sleep");

  wake_exit_a: assert property (st_q == smw_pkg::SMW_SLEEP && wake_any // [R08]
    |=> st_q == smw_pkg::SMW_WAIT || st_q == smw_pkg::SMW_TWOSPD)
    else $error("wake event did not end sleep");

  wait_unclk_a: assert property (st_q == smw_pkg::SMW_WAIT && !tgt_ready // [R09]
    |=> st_q == smw_pkg::SMW_WAIT && !core_en_q)
    else $error("core clocked before source ready");

  fast_wake_a: assert property (st_q == smw_pkg::SMW_SLEEP && wake_any // [R10]
    && fast_wake |=> core_en_q && core_src_q == smw_pkg::SEL_INT)
    else $error("fast start did not use internal oscillator");

  pri_flag_a: assert property (st_q == smw_pkg::SMW_WAIT && tgt_ready // [R11]
    && tgt_idx == smw_pkg::SRC_PRI |=> flags_q[smw_pkg::SRC_PRI] && core_en_q)
    else $error("primary running flag not set after wake");

  wake_keep_a: assert property (st_q == smw_pkg::SMW_SLEEP && wake_any // [R12]
    && !dev_reset && !wr_ctrl |=> $stable(ctrl_q))
    else $error("wake changed idle select or clock select");

  stack_push_a: assert property (vec_take && bus.sp < 5'(smw_pkg::STK_DEPTH) // [R13]
    |=> bus.sp == $past(bus.sp) + 5'h01 && bus.tos == $past(bus.pc))
    else $error("interrupt wake did not push the program counter");

  vector_load_a: assert property (vec_take |=> bus.pc == // [R14]
    ($past(irq_high_pri) ? smw_pkg::VEC_HIGH : smw_pkg::VEC_LOW))
    else $error("interrupt wake did not load the vector");

  slow_wake_c: cover property (st_q == smw_pkg::SMW_SLEEP ##1
    st_q == smw_pkg::SMW_WAIT ##[1:50] st_q == smw_pkg::SMW_RUN);
  fast_wake_c: cover property (st_q == smw_pkg::SMW_TWOSPD ##[1:50]
    st_q == smw_pkg::SMW_RUN);
  vec_wake_c:  cover property (vec_take && irq_high_pri);
  idle_wake_c: cover property (st_q == smw_pkg::SMW_IDLE ##1 st_q == smw_pkg::SMW_RUN);
endmodule : smw_top

// ==== verif/test_sleep_mode_entry_and_wake.sv ====
// Self-checking bench for the sleep entry and wake controller, driven over its register bus.
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_sleep_mode_entry_and_wake;
  logic        ref_clk;
  logic        rst_n;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  logic        irq_req;
  logic        irq_high_pri;
  logic        wdog_timeout;
  logic        dev_reset;
  logic [2:0]  src_ready;
  wire         core_clk_en;
  wire  [1:0]  core_clk_src;
  wire         cpu_halted;
  wire  [2:0]  osc_en;
  wire  [20:0] prog_counter;
  int          fails;
  int          total_checks;
  logic [31:0] q;

  smw_top u_dut (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .irq_req         (irq_req),
    .irq_high_pri    (irq_high_pri),
    .wdog_timeout    (wdog_timeout),
    .dev_reset       (dev_reset),
    .src_ready       (src_ready),
    .core_clk_en     (core_clk_en),
    .core_clk_src    (core_clk_src),
    .cpu_halted      (cpu_halted),
    .osc_en          (osc_en),
    .prog_counter    (prog_counter)
  );

  always #25 ref_clk = ~ref_clk;

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // Waitrequest is sampled at the rising edge, the same edge at which the slave takes the request.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, avs_waitrequest, 1'b0);
      test_done();
    end
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    bus(1'b0, a, 32'h00000000, v);
  endtask : rd

  // Polls cpu_halted (sel 0) or core_clk_en (sel 1) on falling edges, with a bound.
  task automatic wait_on(input int sel, input logic want);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (((sel == 0) ? cpu_halted : core_clk_en) !== want && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(((sel == 0) ? cpu_halted : core_clk_en), want)
  endtask : wait_on

  // Drives one wake event for a single clock: 0 interrupt, 1 watchdog, 2 device reset.
  task automatic wake(input int kind);
    @(posedge ref_clk);
    irq_req     <= (kind == 0);
    wdog_timeout <= (kind == 1);
    dev_reset   <= (kind == 2);
    @(posedge ref_clk);
    irq_req     <= 1'b0;
    wdog_timeout <= 1'b0;
    dev_reset   <= 1'b0;
  endtask : wake

  task automatic go_sleep(input logic [31:0] ctrl);
    wr(smw_pkg::OFF_CTRL, ctrl);
    wr(smw_pkg::OFF_CMD, 32'h00000001);
    wait_on(0, 1'b1);
  endtask : go_sleep

  initial begin
    repeat (6000) @(posedge ref_clk);
    fails++;
    test_done();
  end

  initial begin
    logic [20:0] pcv [2];
    logic [31:0] ctl [2];
    logic [20:0] vec [2];
    pcv = '{21'h000123, 21'h000456};
    ctl = '{32'h00000080, 32'h00000100};
    vec = '{smw_pkg::VEC_HIGH, smw_pkg::VEC_LOW};
    ref_clk = 1'b0;
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    irq_req = 1'b0;
    irq_high_pri = 1'b1;
    wdog_timeout = 1'b0;
    dev_reset = 1'b0;
    src_ready = 3'h1;
    fails = 0;
    total_checks = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(smw_pkg::OFF_CTRL, q);
    `CHK(q, 32'h00000000)
    rd(smw_pkg::OFF_STAT, q);
    `CHK(q, 32'h00000001)
    rd(5'h18, q);
    `CHK(q, 32'h00000000)
    $display("Test reset done");
    // A switch to the secondary source is left pending when the sleep command arrives.
    go_sleep(32'h00000002);
    `CHK(core_clk_en, 1'b0)
    repeat (2) @(negedge ref_clk);
    `CHK(osc_en, 3'h0)
    rd(smw_pkg::OFF_STAT, q);
    `CHK(q, 32'h00000008)
    wake(0);
    repeat (4) @(negedge ref_clk);
    `CHK(core_clk_en, 1'b0)
    `CHK(prog_counter, 21'h000000)
    @(posedge ref_clk);
    src_ready <= 3'h3;
    wait_on(1, 1'b1);
    `CHK(core_clk_src, 2'h1)
    rd(smw_pkg::OFF_STAT, q);
    `CHK(q[1], 1'b1)
    rd(smw_pkg::OFF_CTRL, q);
    `CHK(q, 32'h00000002)
    $display("Test plain sleep done");
    go_sleep(32'h00000068);
    @(posedge ref_clk);
    src_ready <= 3'h6;
    repeat (2) @(negedge ref_clk);
    `CHK(osc_en[2], 1'b1)
    `CHK(osc_en[1], 1'b1)
    `CHK(osc_en[0], 1'b0)
    wake(1);
    repeat (3) @(negedge ref_clk);
    `CHK(core_clk_en, 1'b1)
    `CHK(core_clk_src[1], 1'b1)
    `CHK(cpu_halted, 1'b1)
    rd(smw_pkg::OFF_STAT, q);
    `CHK(q[0], 1'b0)
    src_ready <= 3'h7;
    wait_on(0, 1'b0);
    `CHK(core_clk_src, 2'h0)
    rd(smw_pkg::OFF_STAT, q);
    `CHK(q[0], 1'b1)
    rd(smw_pkg::OFF_CTRL, q);
    `CHK(q, 32'h00000068)
    $display("Test fast wake done");
    src_ready <= 3'h1;
    for (int i = 0; i < 2; i++) begin
      wr(smw_pkg::OFF_PC, {11'h000, pcv[i]});
      go_sleep(ctl[i]);
      @(posedge ref_clk);
      irq_high_pri <= (i == 0);
      wake(0);
      wait_on(0, 1'b0);
      `CHK(prog_counter, vec[i])
      rd(smw_pkg::OFF_SP, q);
      `CHK(q, 32'(i + 1))
      rd(smw_pkg::OFF_TOS, q);
      `CHK(q, {11'h000, pcv[i]})
    end
    $display("Test vector wake done");
    go_sleep(32'h00000001);
    `CHK(core_clk_en, 1'b1)
    rd(smw_pkg::OFF_STAT, q);
    `CHK(q[4:3], 2'h2)
    wake(0);
    wait_on(0, 1'b0);
    $display("Test idle done");
    go_sleep(32'h00000060);
    wake(2);
    wait_on(0, 1'b0);
    rd(smw_pkg::OFF_CTRL, q);
    `CHK(q, 32'h00000000)
    `CHK(prog_counter, smw_pkg::VEC_LOW)
    $display("Test device reset wake done");
    test_done();
  end
endmodule : test_sleep_mode_entry_and_wake
